// ### hw/tspwm_channel.sv
// Shared-timer PWM block: time base, register port and one waveform per channel
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ns
module tspwm_channel #(
  parameter int NUM_CH = 2
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [tspwm_pkg::ADDR_W-1:0] addr_i,
  input wire logic [tspwm_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [tspwm_pkg::DATA_W-1:0] rd_data_o,
  input wire logic sleep_i,
  output logic [NUM_CH-1:0] pwm_o
);

  // Shared timer state
  logic [7:0] period_limit;
  logic [7:0] next_period_limit;
  tspwm_pkg::tspwm_tctrl_t shared_timer_control;
  tspwm_pkg::tspwm_tctrl_t next_shared_timer_control;
  logic [tspwm_pkg::CNT_W-1:0] timebase_count;
  logic [tspwm_pkg::CNT_W-1:0] next_timebase_count;
  logic [tspwm_pkg::PRE_W-1:0] pre;
  logic [tspwm_pkg::PRE_W-1:0] next_pre;
  logic [tspwm_pkg::PRE_W-1:0] pre_max;
  logic [tspwm_pkg::SUB_W-1:0] next_sub;
  logic [tspwm_pkg::DUTY_W-1:0] next_time_base;
  logic [tspwm_pkg::DUTY_W-1:0] period_top;
  logic sleep_s1;
  logic sleep_s2;
  logic run;
  logic tick;
  logic at_limit;
  logic restart;

  // Read port state
  logic [tspwm_pkg::DATA_W-1:0] next_rd_data;

  // Per-channel views for the read mux
  logic [1:0] duty_low [NUM_CH];
  logic [7:0] duty_high [NUM_CH];
  tspwm_pkg::tspwm_cctrl_t channel_control [NUM_CH];

  // Byte address of a channel register
  function automatic logic [7:0] ch_addr(input int ch, input logic [7:0] ofs);
    logic [7:0] base;
    base = 8'(tspwm_pkg::OFS_CH_BASE + ch * tspwm_pkg::CH_STRIDE);
    return 8'(base + ofs);
  endfunction : ch_addr

  // Sleep arrives from outside this clock domain, so two flops first
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      sleep_s1 <= 1'b0;
      sleep_s2 <= 1'b0;
    end
    else
    begin
      sleep_s1 <= sleep_i;
      sleep_s2 <= sleep_s1;
    end
  end

  // Prescaler wrap for the selected ratio
  always_comb
  begin
    case (shared_timer_control.prescale)
      tspwm_pkg::PS_1:
      begin
        pre_max = tspwm_pkg::PRE_MAX_1;
      end
      tspwm_pkg::PS_4:
      begin
        pre_max = tspwm_pkg::PRE_MAX_4;
      end
      tspwm_pkg::PS_16:
      begin
        pre_max = tspwm_pkg::PRE_MAX_16;
      end
      default:
      begin
        pre_max = tspwm_pkg::PRE_MAX_64;
      end
    endcase
  end

  // Sub-count bits of the time base that stands after this edge; comparing
  // against the coming time base lets the output fall in the very cycle of
  // the match, so the pulse lasts duty steps and not one clock more
  always_comb
  begin
    case (shared_timer_control.prescale)
      tspwm_pkg::PS_1:
      begin
        next_sub = next_pre[1:0];
      end
      tspwm_pkg::PS_4:
      begin
        next_sub = next_pre[3:2];
      end
      tspwm_pkg::PS_16:
      begin
        next_sub = next_pre[5:4];
      end
      default:
      begin
        next_sub = next_pre[7:6];
      end
    endcase
  end

  // The timer only counts on the system clock/4 source and outside sleep;
  // the postscaler field is stored but never reaches the period
  assign run = shared_timer_control.on & ~shared_timer_control.clk_alt & ~sleep_s2;
  assign tick = run & (pre == pre_max);
  assign at_limit = (timebase_count == period_limit);
  assign restart = tick & at_limit;
  assign next_time_base = {next_timebase_count, next_sub};
  assign period_top = {period_limit, 2'h3};

  // Shared timer next state and register writes
  always_comb
  begin
    next_period_limit = period_limit;
    next_shared_timer_control = shared_timer_control;
    next_pre = pre;
    next_timebase_count = timebase_count;
    if (wr_i && addr_i == tspwm_pkg::OFS_PERIOD)
    begin
      next_period_limit = wr_data_i;
    end
    if (wr_i && addr_i == tspwm_pkg::OFS_TCTRL)
    begin
      next_shared_timer_control = tspwm_pkg::tspwm_tctrl_t'(wr_data_i);
    end
    if (run)
    begin
      next_pre = (pre == pre_max) ? '0 : 8'(pre + 8'h01);
    end
    if (tick)
    begin
      // Count clears on the increment after it equals the limit
      next_timebase_count = at_limit ? '0 : 8'(timebase_count + 8'h01);
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      period_limit <= tspwm_pkg::PERIOD_RST;
      shared_timer_control <= tspwm_pkg::TCTRL_RST;
      pre <= '0;
      timebase_count <= '0;
    end
    else
    begin
      period_limit <= next_period_limit;
      shared_timer_control <= next_shared_timer_control;
      pre <= next_pre;
      timebase_count <= next_timebase_count;
    end
  end

  // One waveform generator per channel, all on the shared time base
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc = gc + 1)
    begin : g_ch
      localparam logic [7:0] A_DLOW = ch_addr(gc, tspwm_pkg::OFS_DLOW);
      localparam logic [7:0] A_DHIGH = ch_addr(gc, tspwm_pkg::OFS_DHIGH);
      localparam logic [7:0] A_CCTRL = ch_addr(gc, tspwm_pkg::OFS_CCTRL);
      logic [1:0] dl;
      logic [1:0] next_dl;
      logic [7:0] dh;
      logic [7:0] next_dh;
      tspwm_pkg::tspwm_cctrl_t cc;
      tspwm_pkg::tspwm_cctrl_t next_cc;
      logic [tspwm_pkg::DUTY_W-1:0] duty_buf;
      logic [tspwm_pkg::DUTY_W-1:0] next_duty_buf;
      logic [tspwm_pkg::DUTY_W-1:0] duty_value;
      logic wave;
      logic next_wave;
      logic out;
      logic next_out;
      logic full;

      // Software view: high byte is the MSBs, low byte bits 7:6 the LSBs
      assign duty_value = {dh, dl};
      // A buffered duty past the last time base step can never match
      assign full = (duty_buf > period_top);

      always_comb
      begin
        next_dl = dl;
        next_dh = dh;
        next_cc = cc;
        next_duty_buf = duty_buf;
        next_wave = wave;
        // Duty writes land only in the shadow fields, never in the compare path; invert writes take effect at once, a cleared enable one clock later
        if (wr_i && addr_i == A_DLOW)
        begin
          next_dl = wr_data_i[tspwm_pkg::DLOW_MSB:tspwm_pkg::DLOW_LSB];
        end
        if (wr_i && addr_i == A_DHIGH)
        begin
          next_dh = wr_data_i;
        end
        if (wr_i && addr_i == A_CCTRL)
        begin
          next_cc.enable = wr_data_i[tspwm_pkg::CC_EN_BIT];
          next_cc.invert = wr_data_i[tspwm_pkg::CC_INV_BIT];
        end
        if (!cc.enable)
        begin
          next_wave = 1'b0;
        end
        else if (restart)
        begin
          // Latch the pair and start a new period together
          next_duty_buf = duty_value;
          next_wave = (duty_value != '0);
        end
        else if (run && next_time_base == duty_buf && !full)
        begin
          next_wave = 1'b0;
        end
        next_out = next_wave ^ next_cc.invert;
      end

      always_ff @(posedge clock_i)
      begin
        if (sys_rst_i)
        begin
          dl <= tspwm_pkg::DUTY_RST[1:0];
          dh <= tspwm_pkg::DUTY_RST[9:2];
          cc <= '0;
          duty_buf <= tspwm_pkg::DUTY_RST;
          wave <= 1'b0;
          out <= 1'b0;
        end
        else
        begin
          dl <= next_dl;
          dh <= next_dh;
          cc <= next_cc;
          duty_buf <= next_duty_buf;
          wave <= next_wave;
          out <= next_out;
        end
      end

      assign pwm_o[gc] = out;
      assign duty_low[gc] = dl;
      assign duty_high[gc] = dh;
      assign channel_control[gc] = cc;
    end
  endgenerate

  // Read mux; unmapped addresses and idle cycles read as zero
  always_comb
  begin
    next_rd_data = '0;
    if (rd_i)
    begin
      if (addr_i == tspwm_pkg::OFS_PERIOD)
      begin
        next_rd_data = period_limit;
      end
      if (addr_i == tspwm_pkg::OFS_TCTRL)
      begin
        next_rd_data = shared_timer_control;
      end
      if (addr_i == tspwm_pkg::OFS_COUNT)
      begin
        next_rd_data = timebase_count;
      end
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (addr_i == ch_addr(c, tspwm_pkg::OFS_DLOW))
        begin
          next_rd_data[tspwm_pkg::DLOW_MSB:tspwm_pkg::DLOW_LSB] = duty_low[c];
        end
        if (addr_i == ch_addr(c, tspwm_pkg::OFS_DHIGH))
        begin
          next_rd_data = duty_high[c];
        end
        if (addr_i == ch_addr(c, tspwm_pkg::OFS_CCTRL))
        begin
          next_rd_data[tspwm_pkg::CC_EN_BIT] = channel_control[c].enable;
          next_rd_data[tspwm_pkg::CC_OUT_BIT] = pwm_o[c];
          next_rd_data[tspwm_pkg::CC_INV_BIT] = channel_control[c].invert;
        end
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      rd_data_o <= '0;
    end
    else
    begin
      rd_data_o <= next_rd_data;
    end
  end

endmodule : tspwm_channel

// ### hw/tspwm_pkg.sv
// Constants, field layouts and carrier types of the timer-shared PWM channel block
package tspwm_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W = 8;
  localparam int DUTY_W = 10;
  localparam int PRE_W = 8;
  localparam int SUB_W = 2;

  // Register offsets; channel registers repeat at a fixed stride
  localparam logic [7:0] OFS_PERIOD = 8'h00;
  localparam logic [7:0] OFS_TCTRL = 8'h01;
  localparam logic [7:0] OFS_COUNT = 8'h02;
  localparam logic [7:0] OFS_CH_BASE = 8'h04;
  localparam logic [7:0] CH_STRIDE = 8'h04;
  localparam logic [7:0] OFS_DLOW = 8'h00;
  localparam logic [7:0] OFS_DHIGH = 8'h01;
  localparam logic [7:0] OFS_CCTRL = 8'h02;

  // Field positions
  localparam int DLOW_MSB = 7;
  localparam int DLOW_LSB = 6;
  localparam int CC_EN_BIT = 7;
  localparam int CC_OUT_BIT = 5;
  localparam int CC_INV_BIT = 4;

  // Reset values
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [7:0] TCTRL_RST = 8'h00;
  localparam logic [9:0] DUTY_RST = 10'h000;

  // Prescale select codes and their wrap values
  localparam logic [1:0] PS_1 = 2'h0;
  localparam logic [1:0] PS_4 = 2'h1;
  localparam logic [1:0] PS_16 = 2'h2;
  localparam logic [1:0] PS_64 = 2'h3;
  localparam logic [7:0] PRE_MAX_1 = 8'h03;
  localparam logic [7:0] PRE_MAX_4 = 8'h0F;
  localparam logic [7:0] PRE_MAX_16 = 8'h3F;
  localparam logic [7:0] PRE_MAX_64 = 8'hFF;

  // Shared timer control byte, laid out bit for bit as the register
  typedef struct packed {
    logic on;
    logic clk_alt;
    logic [1:0] prescale;
    logic [3:0] postscale;
  } tspwm_tctrl_t;

  // Per-channel control bits
  typedef struct packed {
    logic enable;
    logic invert;
  } tspwm_cctrl_t;

endpackage : tspwm_pkg

// ### test/tspwm_channel_checker.sv
// Port-level assertions for the shared-timer PWM block
`timescale 1ns/1ns
module tspwm_channel_checker #(
  parameter int NUM_CH = 2
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rd_data_o,
  input wire logic sleep_i,
  input wire logic [NUM_CH-1:0] pwm_o
);
  logic run;
  logic en0;
  logic inv0;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  // Shadow of timer run and channel 0 control, taken from software writes only
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      {run, en0, inv0} <= 3'h0;
    else if (wr_i && addr_i == 8'h01)
      run <= wr_data_i[7] && !wr_data_i[6];
    else if (wr_i && addr_i == 8'h06)
      {en0, inv0} <= {wr_data_i[7], wr_data_i[4]};
  end

  AST_READ_IDLE_ZERO: assert property (!rd_i |=> rd_data_o == 8'h00)
    else $error("read data not zero");
  AST_RESET_CLEARS: assert property (disable iff (1'b0)
    sys_rst_i |=> pwm_o == '0 && rd_data_o == 8'h00) else $error("reset left output");
  // Five cycles cover the two-flop sync of the sleep request
  AST_SLEEP_FREEZE: assert property ((sleep_i && !wr_i)[*5] |=> $stable(pwm_o))
    else $error("output moved in sleep");
  AST_STATUS_BIT: assert property (rd_i && addr_i == 8'h06 |=>
    rd_data_o[5] == $past(pwm_o[0])) else $error("status bit wrong");
  AST_PERIOD_READBACK: assert property (wr_i && addr_i == 8'h00 ##1
    rd_i && addr_i == 8'h00 |=> rd_data_o == $past(wr_data_i, 2)) else $error("period lost");
  AST_DISABLED_LEVEL: assert property ((!en0 && $stable(inv0))[*3] |->
    pwm_o[0] == inv0) else $error("disabled level wrong");
  AST_COUNT_HELD_OFF: assert property (rd_i && addr_i == 8'h02 && !run ##1
    rd_i && addr_i == 8'h02 && !run |=> rd_data_o == $past(rd_data_o))
    else $error("count moved while stopped");
  AST_RISE_AT_RESTART: assert property ($rose(pwm_o[0]) && en0 && !inv0 &&
    $past(en0, 2) && !$past(inv0, 2) && rd_i && addr_i == 8'h02 |=> rd_data_o == 8'h00)
    else $error("rise away from restart");
endmodule : tspwm_channel_checker

bind tspwm_channel tspwm_channel_checker #(.NUM_CH(NUM_CH)) i_chk (.clock_i(clock_i),
  .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
  .rd_i(rd_i), .rd_data_o(rd_data_o), .sleep_i(sleep_i), .pwm_o(pwm_o));

// ### test/tspwm_pin_model.sv
// Output pad model with pull-up; measures rise-to-rise spacing of the pad
`timescale 1ns/1ns
module tspwm_pin_model (
  input wire logic clock_i,
  input wire logic level_i,
  input wire logic dir_i,
  output logic pin_o,
  output int per_o
);
  int cnt;
  bit last;

  // Pad only follows the channel while the direction bit is clear
  assign pin_o = dir_i ? 1'b1 : level_i;

  // Spacing seen by a downstream peripheral
  always_ff @(posedge clock_i)
  begin
    last <= pin_o;
    cnt <= (pin_o && !last) ? 1 : cnt + 1;
    if (pin_o && !last)
      per_o <= cnt;
  end
endmodule : tspwm_pin_model

// ### test/testbench.sv
// Self-checking bench for the shared-timer PWM block
`timescale 1ns/1ns
module testbench;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic sleep_i = 1'b0;
  logic dir = 1'b1;
  logic [7:0] rd_data_o;
  logic [1:0] pwm_o;
  logic pin;
  int per, n_errors, check_count;
  integer ones0, ones1;
  logic [31:0] seed = 32'h6B8A7E37;

  always #20 clock_i = ~clock_i;

  tspwm_channel #(.NUM_CH(2)) i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .sleep_i(sleep_i), .pwm_o(pwm_o));
  tspwm_pin_model i_pin (.clock_i(clock_i), .level_i(pwm_o[0]), .dir_i(dir),
    .pin_o(pin), .per_o(per));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // High cycles over two whole periods; duty past the period saturates
  function int exp_high(int d, int len, int ps, logic en, logic inv);
    int h;
    h = en ? 2 * ((d * ps < len) ? d * ps : len) : 0;
    return inv ? 2 * len - h : h;
  endfunction : exp_high

  task chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    d = rd_data_o;
  endtask : rd

  // Back-to-back count reads while summing both outputs
  task poll(input int n, input logic [7:0] lim);
    ones0 = 0;
    ones1 = 0;
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= 8'h02;
    for (int j = 0; j < n; j++)
    begin
      @(posedge clock_i);
      #1;
      ones0 += pin;
      ones1 += pwm_o[1];
      chk(rd_data_o <= lim, "count over limit");
    end
    @(posedge clock_i);
    rd_i <= 1'b0;
  endtask : poll

  task do_reset();
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    sys_rst_i <= 1'b0;
  endtask : do_reset

  task complete_run();
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  // Reset values, a hole, a read-only write, then random configurations per prescale
  initial
  begin
    logic [7:0] ra [6];
    logic [7:0] v, p;
    logic [9:0] d0, d1;
    logic [1:0] code, c1;
    logic inv0;
    int ps, len;
    ra = '{8'h00, 8'h01, 8'h02, 8'h06, 8'h05, 8'h0B};
    do_reset();
    foreach (ra[i])
    begin
      rd(ra[i], v);
      chk(v === (ra[i] == 8'h00 ? 8'hFF : 8'h00), "reset value");
    end
    wr(8'h02, 8'hA5);
    poll(3, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      code = 2'(k);
      ps = 1 << (2 * code);
      p = 8'(rnd()) & (8'hFF >> (2 * code));
      len = (p + 1) * 4 * ps;
      d0 = k == 0 ? 10'h000 : k == 1 ? 10'h3FF : 10'(rnd() % (len / ps + 2));
      d1 = 10'(rnd());
      c1 = 2'(rnd());
      inv0 = (k == 2 || k == 5);
      do_reset();
      dir <= 1'b0;
      // One idle edge after reset, then the period write with its readback behind it
      @(posedge clock_i);
      wr_i <= 1'b1;
      addr_i <= 8'h00;
      wr_data_i <= p;
      @(posedge clock_i);
      wr_i <= 1'b0;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1;
      chk(rd_data_o === p, "period readback");
      wr(8'h05, d0[9:2]);
      wr(8'h04, {d0[1:0], 6'(rnd())});
      wr(8'h06, {3'h4, inv0, 4'h0});
      wr(8'h09, d1[9:2]);
      wr(8'h08, {d1[1:0], 6'h00});
      wr(8'h0A, {c1[0], 2'h0, c1[1], 4'h0});
      wr(8'h01, {2'h2, code, 4'(rnd())});
      repeat (2 * len + 8) @(posedge clock_i);
      poll(2 * len, p);
      chk(ones0 === exp_high(d0, len, ps, 1'b1, inv0), "ch0 high time");
      chk(ones1 === exp_high(d1, len, ps, c1[0], c1[1]), "ch1 high time");
      if (d0 != 0 && d0 < len / ps)
        chk(per === len, "period length");
    end
    // Sleep holds the count
    sleep_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    rd(8'h02, v);
    repeat (20) @(posedge clock_i);
    rd(8'h02, p);
    chk(p === v, "count moved in sleep");
    @(posedge clock_i);
    sleep_i <= 1'b0;
    complete_run();
  end

  // Watchdog: eight configurations of at most about 4200 cycles each, so
  // 60000 cycles leaves ample margin while keeping a hang short
  initial
  begin
    repeat (60000) @(posedge clock_i);
    n_errors++;
    complete_run();
  end
endmodule : testbench
